// ---- hw/twi_target_pkg.sv ----
// Constants shared by the two-wire target block and its byte FIFO.
// Assumes a single system clock domain plus the link clock taken from SCL.
package twi_target_pkg;
    localparam logic [6:0] DEV_ADDR = 7'h4c;
    localparam logic [7:0] WRITE_ADDR_BYTE = 8'h98;
    localparam logic [7:0] READ_ADDR_BYTE = 8'h99;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_RESET = 4'h0;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam logic [1:0] SYNC_RESET = 2'h3;
endpackage

// ---- hw/byte_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides.
// Assumes the caller's clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] cnt_reg;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;

    // Room while fewer than DEPTH words are held
    assign in_ready_o = (cnt_reg < (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rd_reg];

    always_ff @(posedge sys_clk_i) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---- hw/twi_target.sv ----
// Two-wire bus target: address match, register pointer, write and read bytes.
// Assumes SCL is the link clock (stops between frames) and SDA is open-drain.
// Written bytes leave through a FIFO on sys_clk; read data is served from a
// pointer-indexed register image supplied by the surrounding device.
`timescale 1ns/1ps
module twi_target
    import twi_target_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic busy_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_PTR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } phase_e;

    // START/STOP detection: SDA edges while SCL high, clocked by SDA itself
    logic start_tgl_reg;
    logic stop_tgl_reg;
    always_ff @(negedge sda_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_tgl_reg <= 1'b0;
        end else if (scl_i) begin
            start_tgl_reg <= ~start_tgl_reg;
        end
    end
    always_ff @(posedge sda_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stop_tgl_reg <= 1'b0;
        end else if (scl_i) begin
            stop_tgl_reg <= ~stop_tgl_reg;
        end
    end

    // Link domain sees START via a seen-toggle compare on SCL rising edges
    logic start_seen_reg;
    logic stop_seen_reg;
    wire start_pend = (start_seen_reg != start_tgl_reg);
    wire stop_pend = (stop_seen_reg != stop_tgl_reg);

    phase_e phase_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic [7:0] ptr_reg;
    logic [7:0] tx_reg;
    logic ack_reg;
    logic drive_reg;
    logic wr_tgl_reg;
    logic [7:0] wr_addr_l_reg;
    logic [7:0] wr_data_l_reg;
    logic master_nak_reg;

    wire [7:0] rx_byte = {shift_reg[6:0], sda_i};
    wire byte_done = (bit_reg == BIT_LAST);
    wire in_ack = (bit_reg == 4'h8);
    wire addr_hit_w = (rx_byte == WRITE_ADDR_BYTE);
    wire addr_hit_r = (rx_byte == READ_ADDR_BYTE);
    wire fifo_in_ready;

    always_ff @(posedge scl_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_reg <= ST_IDLE;
            bit_reg <= BIT_RESET;
            shift_reg <= '0;
            ptr_reg <= PTR_RESET;
            ack_reg <= 1'b0;
            start_seen_reg <= 1'b0;
            stop_seen_reg <= 1'b0;
            wr_tgl_reg <= 1'b0;
            wr_addr_l_reg <= '0;
            wr_data_l_reg <= '0;
            master_nak_reg <= 1'b0;
        end else if (start_pend) begin
            start_seen_reg <= start_tgl_reg;
            stop_seen_reg <= stop_tgl_reg;
            if (stop_pend) begin
                ptr_reg <= PTR_RESET;
            end
            // Pointer kept across repeated START
            phase_reg <= ST_ADDR;
            bit_reg <= 4'h1;
            shift_reg <= {7'h00, sda_i};
            ack_reg <= 1'b0;
            master_nak_reg <= 1'b0;
        end else if (stop_pend) begin
            stop_seen_reg <= stop_tgl_reg;
            ptr_reg <= PTR_RESET;
            phase_reg <= ST_IDLE;
            bit_reg <= BIT_RESET;
            ack_reg <= 1'b0;
        end else if (phase_reg != ST_IDLE && phase_reg != ST_IGNORE) begin
            if (in_ack) begin
                bit_reg <= BIT_RESET;
                ack_reg <= 1'b0;
                // The target's own address acknowledge does not consume a read byte
                if (phase_reg == ST_RDATA && !ack_reg) begin
                    master_nak_reg <= sda_i;
                    ptr_reg <= ptr_reg + 8'h01;
                end
            end else begin
                bit_reg <= bit_reg + 4'h1;
                shift_reg <= rx_byte;
                if (byte_done) begin
                    case (phase_reg)
                        ST_ADDR: begin
                            if (addr_hit_w) begin
                                phase_reg <= ST_PTR;
                                ack_reg <= 1'b1;
                            end else if (addr_hit_r) begin
                                phase_reg <= ST_RDATA;
                                ack_reg <= 1'b1;
                            end else begin
                                phase_reg <= ST_IGNORE;
                            end
                        end
                        ST_PTR: begin
                            ptr_reg <= rx_byte;
                            phase_reg <= ST_WDATA;
                            ack_reg <= 1'b1;
                        end
                        ST_WDATA: begin
                            // Byte only leaves here, so a bare pointer write stores nothing
                            wr_addr_l_reg <= ptr_reg;
                            wr_data_l_reg <= rx_byte;
                            wr_tgl_reg <= ~wr_tgl_reg;
                            ptr_reg <= ptr_reg + 8'h01;
                            ack_reg <= 1'b1;
                        end
                        default: begin
                            phase_reg <= phase_reg;
                        end
                    endcase
                end
            end
        end
    end

    // Read byte preload and SDA drive change on SCL falling edges
    logic [2:0] tx_idx_reg;
    always_ff @(negedge scl_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drive_reg <= 1'b0;
            tx_reg <= '0;
        end else if (phase_reg == ST_RDATA && !start_pend && !stop_pend) begin
            if (ack_reg) begin
                drive_reg <= 1'b1;
                tx_reg <= rd_data_i;
            end else if (bit_reg == BIT_RESET && !master_nak_reg) begin
                tx_reg <= rd_data_i;
                drive_reg <= ~rd_data_i[7];
            end else if (bit_reg == BIT_RESET) begin
                drive_reg <= 1'b0;
            end else if (bit_reg < 4'h8) begin
                drive_reg <= ~tx_reg[3'h7 - tx_idx_reg];
            end else begin
                drive_reg <= 1'b0;
            end
        end else begin
            drive_reg <= ack_reg;
        end
    end
    assign tx_idx_reg = bit_reg[2:0];

    assign sda_o = 1'b0;
    assign sda_oe_o = drive_reg;
    assign rd_addr_o = ptr_reg;

    // Written bytes cross to sys_clk by toggle, then enter the FIFO
    logic [1:0] wr_sync_reg;
    logic wr_seen_reg;
    logic [7:0] xfer_addr_reg;
    logic [7:0] xfer_data_reg;
    logic xfer_valid_reg;
    logic [1:0] busy_sync_reg;
    wire wr_event = (wr_sync_reg[1] != wr_seen_reg);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_sync_reg <= '0;
            wr_seen_reg <= 1'b0;
            xfer_addr_reg <= '0;
            xfer_data_reg <= '0;
            xfer_valid_reg <= 1'b0;
            busy_sync_reg <= '0;
        end else begin
            wr_sync_reg <= {wr_sync_reg[0], wr_tgl_reg};
            busy_sync_reg <= {busy_sync_reg[0], (phase_reg != ST_IDLE)};
            if (xfer_valid_reg && fifo_in_ready) begin
                xfer_valid_reg <= 1'b0;
            end else if (wr_event && !xfer_valid_reg) begin
                wr_seen_reg <= wr_sync_reg[1];
                xfer_addr_reg <= wr_addr_l_reg;
                xfer_data_reg <= wr_data_l_reg;
                xfer_valid_reg <= 1'b1;
            end
        end
    end

    logic [15:0] fifo_out;
    byte_fifo #(
        .WIDTH(16),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(xfer_valid_reg),
        .in_ready_o(fifo_in_ready),
        .in_data_i({xfer_addr_reg, xfer_data_reg}),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(fifo_out)
    );
    assign wr_addr_o = fifo_out[15:8];
    assign wr_data_o = fifo_out[7:0];
    assign busy_o = busy_sync_reg[1];
endmodule

// ---- tb/twi_target_monitor.sv ----
// Checker for the two-wire target: framing, acknowledge, pointer and FIFO head.
// Assumes it is bound to twi_target and sees the resolved SDA level.
`timescale 1ns/1ps
module twi_target_monitor
    import twi_target_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic [7:0] wr_addr_o,
    input wire logic [7:0] wr_data_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire logic [7:0] rd_addr_o,
    input wire logic busy_o
);
    logic st_t, sp_t, st_s, sp_s;
    logic [3:0] cnt;
    logic [7:0] sh;
    // Toggles mark START and STOP; the SCL side sees them as pending
    always_ff @(negedge sda_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_t <= 1'b0;
        end else begin
            st_t <= st_t ^ scl_i;
        end
    end
    always_ff @(posedge sda_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp_t <= 1'b0;
        end else begin
            sp_t <= sp_t ^ scl_i;
        end
    end
    always_ff @(posedge scl_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {st_s, sp_s, cnt, sh} <= '0;
        end else begin
            {st_s, sp_s} <= {st_t, sp_t};
            sh <= {sh[6:0], sda_i};
            cnt <= (st_t != st_s) ? 4'h1 : cnt + 4'((cnt != 4'h0) && (cnt != 4'ha));
        end
    end
    a_sda_low_only: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        sda_o == 1'b0) else $error("sda driven high");
    a_fifo_head_held: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable({wr_addr_o, wr_data_o}))
        else $error("fifo head lost");
    a_reset_clean: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> !wr_valid_o && !sda_oe_o && rd_addr_o == PTR_RESET)
        else $error("reset state wrong");
    a_idle_released: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $fell(busy_o) |-> !sda_oe_o [*3]) else $error("sda held after frame");
    a_stop_clears_ptr: assert property (@(posedge scl_i) disable iff (!rstn_i)
        sp_t != sp_s |=> rd_addr_o == PTR_RESET) else $error("pointer kept after stop");
    a_addr_acked: assert property (@(posedge scl_i) disable iff (!rstn_i)
        cnt == 4'h8 && sh[7:1] == DEV_ADDR |-> sda_oe_o) else $error("own address not acked");
    a_foreign_quiet: assert property (@(posedge scl_i) disable iff (!rstn_i)
        cnt == 4'h8 && sh[7:1] != DEV_ADDR |-> !sda_oe_o [*8]) else $error("foreign answered");
    a_addr_bits_free: assert property (@(posedge scl_i) disable iff (!rstn_i)
        cnt != 4'h0 && cnt < 4'h8 |-> !sda_oe_o) else $error("sda driven in address");
endmodule
bind twi_target twi_target_monitor u_mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wr_addr_o(wr_addr_o),
    .wr_data_o(wr_data_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
    .rd_addr_o(rd_addr_o), .busy_o(busy_o));

// ---- tb/twi_master_model.sv ----
// Two-wire bus master model: START, STOP and one byte with acknowledge.
// Assumes a pull-up on SDA; SCL rests high between frames.
`timescale 1ns/1ps
module twi_master_model (
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // SDA moves 6 ns after SCL falls, so no data edge looks like START or STOP
    task automatic start();
        #6 sda_oe_o = 1'b0;
        #18 scl_o = 1'b1;
        #24 sda_oe_o = 1'b1;
        #24 scl_o = 1'b0;
    endtask
    task automatic stop();
        #6 sda_oe_o = 1'b1;
        #18 scl_o = 1'b1;
        #24 sda_oe_o = 1'b0;
        #24;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #6 sda_oe_o = !tx[i];
            #18 scl_o = 1'b1;
            rx[i] = sda_i;
            #24 scl_o = 1'b0;
        end
        #6 sda_oe_o = mack;
        #18 scl_o = 1'b1;
        ack = !sda_i;
        #24 scl_o = 1'b0;
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Bench for the two-wire target: master model, register image, scenarios.
// Assumes reads return the register index xor 0x5a.
`timescale 1ns/1ps
module tb_top;
    import twi_target_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic rdy = 1'b0;
    logic scl, m_oe, d_oe, wv, ak, bsy;
    logic [7:0] wa, wd, ra, rx;
    wire sda = !(m_oe | d_oe);
    int num_errors = 0;
    int tests_run = 0;
    initial forever #50 clk = ~clk;
    twi_master_model M (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));
    twi_target DUT (.sys_clk_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(),
        .sda_oe_o(d_oe), .wr_addr_o(wa), .wr_data_o(wd), .wr_valid_o(wv), .wr_ready_i(rdy),
        .rd_addr_o(ra), .rd_data_i(ra ^ 8'h5a), .busy_o(bsy));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wb(input logic [7:0] b, input logic ea);
        M.xfer(b, 1'b0, rx, ak);
        chk("ack", {7'h0, ea}, {7'h0, ak});
    endtask
    task automatic rb(input logic [7:0] e, input logic mack);
        M.xfer(8'hff, mack, rx, ak);
        chk("rd_data", e ^ 8'h5a, rx);
    endtask
    task automatic pop(input logic [7:0] ea, input logic [7:0] ed);
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            #1;
            if (wv === 1'b1) break;
        end
        chk("wr_addr", ea, wa);
        chk("wr_data", ed, wd);
        rdy <= 1'b1;
        @(posedge clk) rdy <= 1'b0;
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Whole run is near 15 us; the watchdog allows far more
    initial begin
        #400000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        chk("busy", 8'h0, {7'h0, bsy});
        M.start();
        wb(WRITE_ADDR_BYTE, 1'b1);
        wb(8'h10, 1'b1);
        chk("busy", 8'h1, {7'h0, bsy});
        for (int i = 0; i < FIFO_DEPTH; i++) wb(8'(8'ha0 + i), 1'b1);
        M.stop();
        for (int i = 0; i < FIFO_DEPTH; i++) pop(8'(8'h10 + i), 8'(8'ha0 + i));
        @(posedge clk);
        chk("wr_valid", 8'h0, {7'h0, wv});
        $display("burst write done");
        M.start();
        wb(WRITE_ADDR_BYTE, 1'b1);
        wb(8'h33, 1'b1);
        M.stop();
        M.start();
        wb(READ_ADDR_BYTE, 1'b1);
        rb(PTR_RESET, 1'b0);
        M.stop();
        repeat (8) @(posedge clk);
        chk("wr_valid", 8'h0, {7'h0, wv});
        $display("stop clears pointer done");
        M.start();
        wb(WRITE_ADDR_BYTE, 1'b1);
        wb(8'h7e, 1'b1);
        M.start();
        wb(READ_ADDR_BYTE, 1'b1);
        rb(8'h7e, 1'b1);
        rb(8'h7f, 1'b1);
        rb(8'h80, 1'b0);
        M.stop();
        chk("sda_oe", 8'h0, {7'h0, d_oe});
        $display("repeated start read done");
        M.start();
        wb(8'h9a, 1'b0);
        wb(8'h55, 1'b0);
        M.stop();
        $display("foreign address done");
        give_verdict();
    end
endmodule
